// ### pkg/vrh_pkg.sv
// Purpose: Shared constants and types for the voice recorder host port
// Assumes: 200 MHz hclk, AHB-Lite register access, 32-bit data
// Notes: Struct layouts fix the register field positions
package vrh_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_VOLUME = 8'h04;
  localparam logic [7:0] REG_FORMAT = 8'h08;
  localparam logic [7:0] REG_GPIO = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_SPI_DATA = 8'h14;
  localparam logic [7:0] REG_MSG_ADDR = 8'h18;
  localparam logic [7:0] REG_PLAY = 8'h1C;
  localparam logic [7:0] REG_FLASH = 8'h20;
  localparam logic [7:0] REG_IRQ = 8'h24;
  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int CLK_MHZ = 200;
  localparam int RESET_PULSE_MS = 50;
  localparam int RESET_PULSE_CYCLES = RESET_PULSE_MS * 1000 * CLK_MHZ;
  localparam int I2S_SCK_HALF_NS = 30;
  localparam int I2S_HALF_CYCLES = (I2S_SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLASH_SCK_HALF_NS = 40;
  localparam int FLASH_HALF_CYCLES = (FLASH_SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int I2S_WS_BITS = 16;
  // Synchroniser lanes
  localparam int IN_SCLK = 0;
  localparam int IN_MOSI = 1;
  localparam int IN_SEL = 2;
  localparam int IN_RST = 3;
  localparam int IN_FMISO = 4;
  localparam int IN_GPIO = 5;
  localparam int IN_W = 13;
  // Codec codes
  localparam logic [2:0] CODEC_ADPCM = 3'h0;
  localparam logic [2:0] CODEC_MULAW = 3'h1;
  localparam logic [2:0] CODEC_DMULAW = 3'h2;
  localparam logic [2:0] CODEC_PCM = 3'h3;
  localparam logic [2:0] CODEC_EADPCM = 3'h4;
  localparam logic [2:0] CODEC_VBR = 3'h5;
  localparam logic [2:0] RATE_LAST = 3'h6;
  localparam logic [1:0] MRATE_LAST = 2'h2;

  // Control fields, bit 0 is spk_neg_line
  typedef struct packed {
    logic powerdown;
    logic i2s_master;
    logic i2s_in_sel;
    logic i2s_pins;
    logic [1:0] clk_src;
    logic [1:0] aux_gain;
    logic agc_en;
    logic spk_bridged;
    logic spk_pos_line;
    logic spk_neg_line;
  } vrh_ctrl_t;
  localparam vrh_ctrl_t CTRL_RST = 12'h800;

  typedef struct packed {
    logic [7:0] master_output_volume;
    logic [7:0] playback_path_volume;
    logic [7:0] input_path_volume;
  } vrh_vol_t;
  localparam vrh_vol_t VOL_RST = 24'h808080;

  typedef struct packed {
    logic playback;
    logic [1:0] mrate;
    logic [2:0] rate_sel;
    logic [3:0] bits;
    logic [2:0] codec;
  } vrh_fmt_t;
  localparam vrh_fmt_t FMT_RST = 13'h0198;

  typedef struct packed {
    logic [7:0] oe;
    logic [7:0] out;
  } vrh_gpio_t;
  localparam vrh_gpio_t GPIO_RST = 16'h0000;

  typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_DATA = 2'b10} vrh_bus_st_t;
  typedef enum logic [1:0] {FL_IDLE = 2'b01, FL_XFER = 2'b10} vrh_fl_st_t;

  // Whole state of the top module
  typedef struct packed {
    vrh_bus_st_t bus;
    logic [7:0] addr;
    logic wr;
    logic [31:0] hrdata;
    logic hready;
    logic [IN_W-1:0] s1;
    logic [IN_W-1:0] s2;
    logic [IN_W-1:0] s3;
    logic [IN_W-1:0] filt;
    logic [2:0] bit_cnt;
    logic [7:0] rx_shift;
    logic [7:0] rx_data;
    logic rx_valid;
    logic busy;
    logic [23:0] tx;
    logic miso;
    logic miso_oe;
    logic irq_req;
    vrh_ctrl_t ctrl;
    vrh_vol_t vol;
    vrh_fmt_t fmt;
    vrh_gpio_t gpio;
    logic [23:0] msg_addr;
    logic [15:0] play_index;
    logic play_macro;
    logic play_pending;
    logic [23:0] rst_cnt;
    logic reset_seen;
    vrh_fl_st_t fl;
    logic [3:0] fl_div;
    logic [2:0] fl_cnt;
    logic [7:0] fl_tx;
    logic [7:0] fl_rx;
    logic fl_sel_n;
    logic fl_sck;
    logic fl_mosi;
    logic fl_hold;
    logic [3:0] i2s_div;
    logic i2s_bck;
    logic [3:0] i2s_bits;
    logic i2s_ws;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
  } vrh_state_t;

  // Format legality per codec, bits, rate and direction
  function automatic logic fmt_legal(input vrh_fmt_t f);
    logic ok;
    ok = 1'b0;
    unique case (f.codec)
      CODEC_ADPCM, CODEC_EADPCM: ok = (f.bits >= 4'h2) && (f.bits <= 4'h5);
      CODEC_MULAW, CODEC_DMULAW: ok = (f.bits >= 4'h6) && (f.bits <= 4'h8);
      CODEC_PCM: ok = (f.bits == 4'h8) || (f.bits == 4'hA) || (f.bits == 4'hC);
      CODEC_VBR: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    if ((f.codec == CODEC_EADPCM || f.codec == CODEC_VBR) && !f.playback) begin
      ok = 1'b0;
    end
    return ok && (f.rate_sel <= RATE_LAST) && (f.mrate <= MRATE_LAST);
  endfunction : fmt_legal
endpackage : vrh_pkg

// ### hdl/vrh_host_port.sv
// Purpose: Host serial port, pin control and configuration of a voice recorder
// Assumes: Pins sampled by hclk through three flip-flops; AHB-Lite slave for software
// Notes: One wait state on every bus transfer; hresp always OKAY
//
// Chosen here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
// How it works
// - Serial output driven only while selected
// - Serial commands accepted only while select low
// - Ready high only when next bit accepted
// - Interrupt is open-drain, pulled low when requested
// - Reset pin high 50 ms resets device
// - Audio clock and word select driven in master
// - Eight GPIO, four shared with audio port
// - Digital audio input replaces analog record source
// - Seven playback rates per master rate
// - Recording codecs ADPCM, mu-law, PCM widths
// - Prompts add enhanced ADPCM and variable rate
// - Device reports recorded message start address
// - Flash addresses span up to 128 Mbit
// - Prompt playback selected by index number
// - Macro scripts run from stored sequences
// - Three 8-bit volume settings
// - Two-bit auxiliary input gain
// - Automatic gain control on analog input
// - Clock source chosen from three options
// - Speaker pins float in power down
// - Device masters the external flash
// - Sample input on rise, update output on fall
// - Ready drops after clock rise while processing
module vrh_host_port
  import vrh_pkg::*;
#(
  parameter int unsigned RST_PULSE_CYCLES = RESET_PULSE_CYCLES
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Host serial port
  input wire logic sclk,
  input wire logic mosi,
  input wire logic host_select_n,
  output logic miso,
  output logic miso_oe,
  output logic ready_busy_n,
  output logic irq_n_out,
  output logic irq_n_oe,
  input wire logic reset_pin,
  // External flash
  output logic flash_select_n,
  output logic flash_sclk,
  output logic flash_mosi,
  input wire logic flash_miso,
  // GPIO, upper four shared with the audio port
  input wire logic [7:0] gpio_in,
  output logic [7:0] gpio_out,
  output logic [7:0] gpio_oe,
  // Analog and clock configuration
  output logic speaker_pos_oe,
  output logic speaker_neg_oe,
  output logic bridged_diff_output,
  output logic speaker_pos_line,
  output logic speaker_neg_line,
  output logic [7:0] input_path_volume,
  output logic [7:0] playback_path_volume,
  output logic [7:0] master_output_volume,
  output logic [1:0] aux_line_input_gain,
  output logic agc_enable,
  output logic [1:0] clock_source,
  output logic record_from_digital
);

  vrh_state_t r; // Registered state
  vrh_state_t n; // Next state

  // Next-state logic
  always_comb begin
    logic [IN_W-1:0] f;
    logic [IN_W-1:0] agree;
    logic sel;
    logic sck_rise;
    logic sck_fall;
    logic sel_fall;
    logic acc;
    logic [31:0] rd;
    n = r;
    f = '0;
    agree = '0;
    rd = '0;
    sel = 1'b0;
    sck_rise = 1'b0;
    sck_fall = 1'b0;
    sel_fall = 1'b0;
    acc = 1'b0;
    // Three-stage synchroniser, change counts when stages two and three agree
    n.s1 = {gpio_in, flash_miso, reset_pin, host_select_n, mosi, sclk};
    n.s2 = r.s1;
    n.s3 = r.s2;
    agree = ~(r.s2 ^ r.s3);
    f = (agree & r.s3) | (~agree & r.filt);
    n.filt = f;
    sel = ~f[IN_SEL];
    sck_rise = f[IN_SCLK] & ~r.filt[IN_SCLK];
    sck_fall = ~f[IN_SCLK] & r.filt[IN_SCLK];
    sel_fall = ~f[IN_SEL] & r.filt[IN_SEL];
    acc = hsel & htrans[1] & hready;

    // Bus slave: address phase then one wait cycle
    unique case (r.bus)
      BUS_IDLE: begin
        n.hready = 1'b1;
        if (acc) begin
          n.addr = {haddr[7:2], 2'b00};
          n.wr = hwrite;
          n.hready = 1'b0;
          n.bus = BUS_DATA;
        end
      end
      BUS_DATA: begin
        n.hready = 1'b1;
        n.bus = BUS_IDLE;
        if (r.wr) begin
          unique case (r.addr)
            REG_CTRL: n.ctrl = vrh_ctrl_t'(hwdata[11:0]);
            REG_VOLUME: n.vol = vrh_vol_t'(hwdata[23:0]);
            REG_FORMAT: n.fmt = vrh_fmt_t'(hwdata[12:0]);
            REG_GPIO: n.gpio = vrh_gpio_t'(hwdata[15:0]);
            REG_SPI_DATA: n.tx = {hwdata[7:0], 16'h0000};
            REG_MSG_ADDR: begin
              // Start address of the last recording, queued for the host
              n.msg_addr = hwdata[23:0];
              n.tx = hwdata[23:0];
            end
            REG_PLAY: begin
              // Prompt by index or macro script, done bit clears pending
              n.play_index = hwdata[15:0];
              n.play_macro = hwdata[16];
              n.play_pending = ~hwdata[31];
            end
            REG_FLASH: begin
              if (r.fl == FL_IDLE && hwdata[9]) begin
                n.fl_sel_n = 1'b1;
              end else if (r.fl == FL_IDLE) begin
                // Start one byte on the flash link
                n.fl = FL_XFER;
                n.fl_tx = hwdata[7:0];
                n.fl_hold = hwdata[8];
                n.fl_sel_n = 1'b0;
                n.fl_mosi = hwdata[7];
                n.fl_div = '0;
                n.fl_cnt = '0;
              end
            end
            REG_IRQ: n.irq_req = hwdata[0];
            default: begin
            end
          endcase
        end else begin
          unique case (r.addr)
            REG_CTRL: rd = {20'h00000, r.ctrl};
            REG_VOLUME: rd = {8'h00, r.vol};
            REG_FORMAT: rd = {18'h00000, fmt_legal(r.fmt), r.fmt};
            REG_GPIO: rd = {8'h00, r.filt[IN_GPIO +: 8], r.gpio};
            REG_STATUS: rd = {26'h0000000, r.reset_seen, r.play_pending, r.fl == FL_XFER,
                              ~r.filt[IN_SEL], r.busy, r.rx_valid};
            REG_SPI_DATA: begin
              // Reading takes the byte and frees the port
              rd = {24'h000000, r.rx_data};
              n.rx_valid = 1'b0;
              n.busy = 1'b0;
            end
            REG_MSG_ADDR: rd = {8'h00, r.msg_addr};
            REG_PLAY: rd = {r.play_pending, 14'h0000, r.play_macro, r.play_index};
            REG_FLASH: rd = {22'h000000, r.fl == FL_XFER, ~r.fl_sel_n, r.fl_rx};
            REG_IRQ: rd = {31'h00000000, r.irq_req};
            default: rd = '0;
          endcase
          n.hrdata = rd;
        end
      end
      default: begin
        n.bus = BUS_IDLE;
        n.hready = 1'b1;
      end
    endcase

    // Host serial port, mode 0
    n.miso_oe = sel;
    if (!sel) begin
      n.bit_cnt = '0;
    end else begin
      if (sel_fall) begin
        n.miso = r.tx[23];
      end
      if (sck_rise) begin
        // Input bit taken on the rising clock edge
        n.rx_shift = {r.rx_shift[6:0], f[IN_MOSI]};
        n.bit_cnt = r.bit_cnt + 3'h1;
        n.busy = 1'b1;
        if (r.bit_cnt == 3'h7) begin
          n.rx_data = {r.rx_shift[6:0], f[IN_MOSI]};
          n.rx_valid = 1'b1;
        end
      end
      if (sck_fall) begin
        // Output bit moves after the falling edge
        n.tx = {r.tx[22:0], 1'b0};
        n.miso = r.tx[22];
        if (!r.rx_valid && r.bit_cnt != 3'h0) begin
          n.busy = 1'b0;
        end
      end
    end

    // Flash master engine
    if (r.fl == FL_XFER) begin
      n.fl_div = r.fl_div + 4'h1;
      if (r.fl_div == 4'(FLASH_HALF_CYCLES - 1)) begin
        n.fl_div = '0;
        if (!r.fl_sck) begin
          n.fl_sck = 1'b1;
          n.fl_rx = {r.fl_rx[6:0], f[IN_FMISO]};
        end else begin
          n.fl_sck = 1'b0;
          n.fl_cnt = r.fl_cnt + 3'h1;
          n.fl_tx = {r.fl_tx[6:0], 1'b0};
          n.fl_mosi = r.fl_tx[6];
          if (r.fl_cnt == 3'h7) begin
            n.fl = FL_IDLE;
            n.fl_sel_n = ~r.fl_hold;
          end
        end
      end
    end

    // Audio bit clock and word select generator for master mode
    if (r.ctrl.i2s_master && r.ctrl.i2s_pins) begin
      n.i2s_div = r.i2s_div + 4'h1;
      if (r.i2s_div == 4'(I2S_HALF_CYCLES - 1)) begin
        n.i2s_div = '0;
        n.i2s_bck = ~r.i2s_bck;
        if (r.i2s_bck) begin
          n.i2s_bits = r.i2s_bits + 4'h1;
          if (r.i2s_bits == 4'(I2S_WS_BITS - 1)) begin
            n.i2s_ws = ~r.i2s_ws;
          end
        end
      end
    end else begin
      n.i2s_div = '0;
      n.i2s_bck = 1'b0;
      n.i2s_bits = '0;
      n.i2s_ws = 1'b0;
    end

    // Pin multiplexing for GPIO and the shared audio pins
    n.pin_out = r.gpio.out;
    n.pin_oe = r.gpio.oe;
    if (r.ctrl.i2s_pins) begin
      n.pin_out[7:4] = {1'b0, n.i2s_bck, n.i2s_ws, 1'b0};
      n.pin_oe[7:4] = {1'b0, r.ctrl.i2s_master, r.ctrl.i2s_master, 1'b1};
    end

    // Long reset pulse on the reset pin
    if (f[IN_RST]) begin
      if (r.rst_cnt != 24'(RST_PULSE_CYCLES)) begin
        n.rst_cnt = r.rst_cnt + 24'h000001;
      end
      if (r.rst_cnt == 24'(RST_PULSE_CYCLES - 1)) begin
        // Return configuration to its reset values
        n.ctrl = CTRL_RST;
        n.vol = VOL_RST;
        n.fmt = FMT_RST;
        n.gpio = GPIO_RST;
        n.irq_req = 1'b0;
        n.play_pending = 1'b0;
        n.reset_seen = 1'b1;
      end
    end else begin
      n.rst_cnt = '0;
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.bus <= BUS_IDLE;
      r.hready <= 1'b1;
      r.ctrl <= CTRL_RST;
      r.vol <= VOL_RST;
      r.fmt <= FMT_RST;
      r.gpio <= GPIO_RST;
      r.fl <= FL_IDLE;
      r.fl_sel_n <= 1'b1;
      r.s1 <= 13'h0004;
      r.s2 <= 13'h0004;
      r.s3 <= 13'h0004;
      r.filt <= 13'h0004;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from state
  assign hrdata = r.hrdata;
  assign hreadyout = r.hready;
  assign hresp = 1'b0;
  assign miso = r.miso;
  assign miso_oe = r.miso_oe;
  assign ready_busy_n = ~r.busy;
  assign irq_n_out = 1'b0;
  assign irq_n_oe = r.irq_req;
  assign flash_select_n = r.fl_sel_n;
  assign flash_sclk = r.fl_sck;
  assign flash_mosi = r.fl_mosi;
  assign gpio_out = r.pin_out;
  assign gpio_oe = r.pin_oe;
  assign speaker_pos_oe = ~r.ctrl.powerdown;
  assign speaker_neg_oe = ~r.ctrl.powerdown;
  assign bridged_diff_output = r.ctrl.spk_bridged;
  assign speaker_pos_line = r.ctrl.spk_pos_line;
  assign speaker_neg_line = r.ctrl.spk_neg_line;
  assign input_path_volume = r.vol.input_path_volume;
  assign playback_path_volume = r.vol.playback_path_volume;
  assign master_output_volume = r.vol.master_output_volume;
  assign aux_line_input_gain = r.ctrl.aux_gain;
  assign agc_enable = r.ctrl.agc_en;
  assign clock_source = r.ctrl.clk_src;
  assign record_from_digital = r.ctrl.i2s_in_sel;

endmodule : vrh_host_port

// ### bench/vrh_host_port_checker.sv
// Purpose: Pin and bus protocol checks on the host port
// Assumes: One hclk domain, hresetn asynchronous active low
// Notes: Serial lags allow for the three-flop synchroniser
`timescale 1ns/1ps
module vrh_host_port_checker (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Serial port
  input wire logic sclk,
  input wire logic host_select_n,
  input wire logic miso_oe,
  input wire logic ready_busy_n,
  input wire logic irq_n_out,
  // Flash and speaker
  input wire logic flash_select_n,
  input wire logic flash_sclk,
  input wire logic speaker_pos_oe,
  input wire logic speaker_neg_oe
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Address phase accepted
  sequence s_take;
    hsel && htrans[1] && hready && hreadyout;
  endsequence
  // One wait state, then done
  sequence s_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  property p_ahb_wait;
    s_take |=> s_wait;
  endproperty
  a_ahb_wait: assert property (p_ahb_wait) else $error("bus wait state wrong");
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("bus response not okay");
  property p_miso_float;
    host_select_n [*8] |-> !miso_oe;
  endproperty
  a_miso_float: assert property (p_miso_float) else $error("miso driven while deselected");
  property p_oe_sel;
    $rose(miso_oe) |-> $past(host_select_n, 2) == 1'b0;
  endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("miso enabled without select");
  property p_rdy_fall;
    $fell(ready_busy_n) |-> ($past(sclk, 2) || $past(sclk, 3) || $past(sclk, 4) || $past(sclk, 6));
  endproperty
  a_rdy_fall: assert property (p_rdy_fall) else $error("ready fell without clock rise");
  property p_irq_od;
    irq_n_out == 1'b0;
  endproperty
  a_irq_od: assert property (p_irq_od) else $error("interrupt pin drives high");
  property p_fl_idle;
    flash_select_n |-> !flash_sclk;
  endproperty
  a_fl_idle: assert property (p_fl_idle) else $error("flash clock runs unselected");
  // Flash clock high phase of eight cycles
  sequence s_fl_high;
    flash_sclk [*8] ##1 !flash_sclk;
  endsequence
  property p_fl_half;
    $rose(flash_sclk) |-> s_fl_high;
  endproperty
  a_fl_half: assert property (p_fl_half) else $error("flash clock half period wrong");
  property p_spk;
    speaker_pos_oe == speaker_neg_oe;
  endproperty
  a_spk: assert property (p_spk) else $error("speaker enables differ");
endmodule : vrh_host_port_checker
bind vrh_host_port vrh_host_port_checker i_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .sclk(sclk), .host_select_n(host_select_n),
  .miso_oe(miso_oe), .ready_busy_n(ready_busy_n), .irq_n_out(irq_n_out),
  .flash_select_n(flash_select_n), .flash_sclk(flash_sclk),
  .speaker_pos_oe(speaker_pos_oe), .speaker_neg_oe(speaker_neg_oe)
);

// ### bench/vrh_host_model.sv
// Purpose: Host controller on the serial command port
// Assumes: Mode 0, 160 ns serial clock, 5 ns hclk
// Notes: Waits for ready before every rising clock edge
`timescale 1ns/1ps
module vrh_host_model (
  // Clock
  input wire logic hclk,
  // Device outputs
  input wire logic miso,
  input wire logic ready_busy_n,
  // Host outputs
  output logic sclk,
  output logic mosi,
  output logic host_select_n
);
  localparam int HALF = 16; // 80 ns half period
  localparam int WAIT_MAX = 500; // Bound on busy wait
  // Idle levels, clock still outside frames
  initial begin
    sclk = 1'b0;
    mosi = 1'b0;
    host_select_n = 1'b1;
  end
  // One byte MSB first, select optional
  task automatic xfer(input logic sel, input logic [7:0] tx, output logic [7:0] rx);
    int n;
    @(posedge hclk);
    host_select_n <= !sel;
    repeat (HALF) @(posedge hclk);
    for (int i = 7; i >= 0; i--) begin
      mosi <= tx[i];
      n = 0;
      while (ready_busy_n !== 1'b1 && n < WAIT_MAX) begin
        @(posedge hclk);
        n++;
      end
      repeat (HALF) @(posedge hclk);
      rx[i] = miso;
      sclk <= 1'b1;
      repeat (HALF) @(posedge hclk);
      sclk <= 1'b0;
    end
    repeat (HALF) @(posedge hclk);
    host_select_n <= 1'b1;
    mosi <= !mosi; // Released line shows inverse
  endtask : xfer
endmodule : vrh_host_model

// ### bench/tb.sv
// Purpose: Self-checking bench for the host port block
// Assumes: 200 MHz hclk, host serial clock of 160 ns
// Notes: Reset pin count shortened to 20 cycles
`timescale 1ns/1ps
module tb
  import vrh_pkg::*;
;
  localparam int RST_N = 20; // Short reset pulse count
  localparam logic [31:0] ALL = 32'hFFFFFFFF; // Full mask
  // One write then one masked read
  typedef struct packed {
    logic [7:0] wa;
    logic [31:0] wd;
    logic [7:0] ra;
    logic [31:0] m;
    logic [31:0] e;
  } vrh_row_t;
  vrh_row_t rows [9] = '{
    '{REG_CTRL, 32'hFFFFF0BF, REG_CTRL, ALL, 32'h000000BF},
    '{REG_VOLUME, 32'h00123456, REG_VOLUME, ALL, 32'h00123456},
    '{REG_GPIO, 32'h00000F5A, REG_GPIO, ALL, 32'h003C0F5A},
    '{REG_MSG_ADDR, ALL, REG_MSG_ADDR, ALL, 32'h00FFFFFF},
    '{8'h28, ALL, 8'h28, ALL, 32'h00000000},
    '{REG_PLAY, 32'h00011234, REG_STATUS, 32'h00000010, 32'h00000010},
    '{REG_PLAY, 32'h80000000, REG_STATUS, 32'h00000010, 32'h00000000},
    '{REG_IRQ, 32'h00000001, REG_IRQ, ALL, 32'h00000001},
    '{REG_PLAY, 32'h0001ABCD, REG_PLAY, ALL, 32'h8001ABCD}};
  // Format words, bit 13 is the legal flag
  logic [13:0] fv [12] = '{14'h2B28, 14'h0B30, 14'h2031, 14'h0049, 14'h203A, 14'h2063,
    14'h004B, 14'h0014, 14'h3014, 14'h3005, 14'h03B1, 14'h0C31};
  logic hclk, hresetn, hsel, hwrite, hready, reset_pin, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, aux_gain, clk_src;
  logic [2:0] hsize;
  logic [7:0] gpio_in, gpio_out, gpio_oe, rx, vol_in, vol_pb, vol_ms;
  logic sclk, mosi, host_select_n, miso, miso_oe, ready_busy_n, irq_n_out, irq_n_oe;
  logic flash_select_n, flash_sclk, flash_mosi, flash_miso;
  logic sp_oe, sn_oe, bridged, sp_line, sn_line, agc, rec_dig;
  int error_cnt, num_checks, base;
  int fl_rises = 0;
  assign hready = hreadyout;
  // Flash echoes its input, inverse while released
  assign flash_miso = flash_select_n ? !flash_mosi : flash_mosi;
  always @(posedge flash_sclk) fl_rises <= fl_rises + 1;
  vrh_host_port #(.RST_PULSE_CYCLES(RST_N)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sclk(sclk), .mosi(mosi), .host_select_n(host_select_n), .miso(miso),
    .miso_oe(miso_oe), .ready_busy_n(ready_busy_n), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe),
    .reset_pin(reset_pin), .flash_select_n(flash_select_n), .flash_sclk(flash_sclk),
    .flash_mosi(flash_mosi), .flash_miso(flash_miso), .gpio_in(gpio_in), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .speaker_pos_oe(sp_oe), .speaker_neg_oe(sn_oe), .bridged_diff_output(bridged),
    .speaker_pos_line(sp_line), .speaker_neg_line(sn_line), .input_path_volume(vol_in),
    .playback_path_volume(vol_pb), .master_output_volume(vol_ms), .aux_line_input_gain(aux_gain),
    .agc_enable(agc), .clock_source(clk_src), .record_from_digital(rec_dig));
  vrh_host_model i_host (.hclk(hclk), .miso(miso), .ready_busy_n(ready_busy_n), .sclk(sclk),
    .mosi(mosi), .host_select_n(host_select_n));
  // Free-running bus clock
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Single AHB transfer, waits on hready
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    // Address phase stands until hready is seen high at a rising edge
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    // Data phase ends, read data taken, at the next edge with hready high
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask : ahb
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    ahb(1'b0, a, 32'h00000000, rd);
    chk(rd & m, e);
  endtask : rc
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up
  // Hang guard
  initial begin
    #100000;
    error_cnt++;
    wrap_up();
  end
  // Main sequence
  initial begin
    {hresetn, htrans, haddr, hwrite, hwdata, reset_pin} = '0;
    {hsel, hsize, gpio_in, error_cnt, num_checks} = {1'b1, 3'h2, 8'h3C, 64'h0};
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    rc(REG_CTRL, ALL, 32'h00000800);
    rc(REG_VOLUME, ALL, 32'h00808080);
    rc(REG_FORMAT, ALL, 32'h00002198);
    rc(REG_GPIO, ALL, 32'h003C0000);
    chk(32'({ready_busy_n, miso_oe, irq_n_oe, flash_select_n}), 32'h9);
    $display("reset values done");
    for (int i = 0; i < 9; i++) begin
      ahb(1'b1, rows[i].wa, rows[i].wd, rd);
      rc(rows[i].ra, rows[i].m, rows[i].e);
    end
    for (int i = 0; i < 12; i++) begin
      ahb(1'b1, REG_FORMAT, {19'h0, fv[i][12:0]}, rd);
      rc(REG_FORMAT, ALL, {18'h0, fv[i]});
    end
    chk({8'h0, vol_ms, vol_pb, vol_in}, 32'h00123456);
    chk(32'({irq_n_oe, gpio_oe[3:0], gpio_out[3:0]}), 32'h1FA);
    ahb(1'b1, REG_IRQ, 32'h0, rd);
    ahb(1'b1, REG_CTRL, 32'h000002A5, rd);
    repeat (4) @(posedge hclk);
    chk(32'({irq_n_oe, clk_src, aux_gain, agc, bridged, sp_line, sn_line}), 32'hA5);
    chk(32'({rec_dig, sp_oe}), 32'h3);
    ahb(1'b1, REG_CTRL, 32'h00000500, rd);
    repeat (40) @(posedge hclk);
    chk(32'(gpio_oe[6:5]), 32'h3);
    ahb(1'b1, REG_CTRL, 32'h00000900, rd);
    repeat (40) @(posedge hclk);
    chk(32'({gpio_oe[6:5], sp_oe}), 32'h0);
    $display("table and pins done");
    ahb(1'b1, REG_MSG_ADDR, 32'h00A5C30F, rd);
    i_host.xfer(1'b1, 8'h96, rx);
    chk(32'(rx), 32'hA5);
    repeat (8) @(posedge hclk);
    chk(32'({ready_busy_n, miso_oe}), 32'h0);
    rc(REG_STATUS, 32'h1, 32'h1);
    rc(REG_SPI_DATA, 32'hFF, 32'h96);
    repeat (4) @(posedge hclk);
    chk(32'(ready_busy_n), 32'h1);
    i_host.xfer(1'b0, 8'hFF, rx);
    rc(REG_STATUS, 32'h3, 32'h0);
    chk(32'({ready_busy_n, miso_oe}), 32'h2);
    $display("serial port done");
    base = fl_rises;
    ahb(1'b1, REG_FLASH, 32'h000000C3, rd);
    for (int n = 0; n < 40 && (n == 0 || rd[9]); n++) begin
      ahb(1'b0, REG_FLASH, 32'h0, rd);
    end
    chk(rd & 32'h3FF, 32'hC3);
    chk(fl_rises - base, 8);
    // Byte with select held, then a release-only write
    ahb(1'b1, REG_FLASH, 32'h0000015A, rd);
    for (int n = 0; n < 40 && (n == 0 || rd[9]); n++) begin
      ahb(1'b0, REG_FLASH, 32'h0, rd);
    end
    chk(rd & 32'h3FF, 32'h15A);
    ahb(1'b1, REG_FLASH, 32'h00000200, rd);
    rc(REG_FLASH, 32'h3FF, 32'h05A);
    $display("flash done");
    ahb(1'b1, REG_VOLUME, 32'h00010203, rd);
    reset_pin <= 1'b1;
    repeat (10) @(posedge hclk);
    reset_pin <= 1'b0;
    rc(REG_VOLUME, ALL, 32'h00010203);
    @(posedge hclk);
    reset_pin <= 1'b1;
    repeat (RST_N + 10) @(posedge hclk);
    reset_pin <= 1'b0;
    rc(REG_VOLUME, ALL, 32'h00808080);
    rc(REG_STATUS, 32'h20, 32'h20);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rc(REG_STATUS, 32'h20, 32'h0);
    $display("reset pin done");
    wrap_up();
  end
endmodule : tb
